/* File: hw/host_cfg_pkg.sv */
package host_cfg_pkg;

  // host i/o space byte addresses
  localparam logic [15:0] IO_PM2_ADDR      = 16'h0022;
  localparam logic [15:0] IO_CFG_ADDR_ADDR = 16'h0cf8;
  localparam logic [15:0] IO_CFG_DATA_ADDR = 16'h0cfc;

  // config-space dword byte offsets of our own bank
  localparam logic [7:0] CFG_ID_OFS      = 8'h00;
  localparam logic [7:0] CFG_CMD_STS_OFS = 8'h04;
  localparam logic [7:0] CFG_SCRATCH_OFS = 8'h50;
  localparam logic [7:0] CFG_UNDEF_OFS   = 8'h54;

  // cfg_address_reg fields
  localparam int CFG_EN_BIT  = 31;
  localparam int CFG_BUS_LSB = 16;
  localparam int CFG_DEV_LSB = 11;
  localparam int CFG_FN_LSB  = 8;
  localparam int CFG_REG_LSB = 2;

  // masks and reset values
  localparam logic [31:0] CFG_ADDR_RW_MASK  = 32'h80ff_fffc;
  localparam logic [31:0] CFG_ADDR_RST      = 32'h0000_0000;
  localparam logic [31:0] PM2_RW_MASK       = 32'h0000_0001;
  localparam logic [31:0] PM2_RST           = 32'h0000_0000;
  localparam logic [31:0] CMD_STS_RW_MASK   = 32'h0000_0006;
  localparam logic [31:0] CMD_STS_W1C_MASK  = 32'h3000_0000;
  localparam logic [31:0] CMD_STS_RST       = 32'h0000_0006;
  localparam logic [31:0] SCRATCH_RW_MASK   = 32'hffff_ffff;
  localparam logic [31:0] SCRATCH_RST       = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_CFG_READ = 32'hffff_ffff;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
  localparam int          STS_EVT_LSB       = 28;
  localparam int          CMD_MEM_EN_BIT    = 1;
  localparam int          PM2_ARB_DIS_BIT   = 0;
  localparam logic [3:0]  BE_DWORD          = 4'hf;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_expansion;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } host_rsp_t;

  typedef struct packed {
    logic [28:0] host_addr;
    logic        host_addr_oe;
    logic [7:0]  tag_data;
    logic        tag_data_oe;
    logic [31:0] exp_ad;
    logic        exp_ad_oe;
    logic [3:0]  exp_cbe;
    logic        exp_cbe_oe;
    logic        host_addr_hold;
    logic        host_burst_ready_n;
    logic        host_next_addr_n;
    logic        host_snoop_strobe_n;
    logic        host_backoff_n;
    logic        tag_write_enable_n;
    logic [5:0]  dram_row_strobe_n;
    logic [1:0]  dram_clk_en;
    logic [3:0]  exp_grant_n;
    logic        exp_grant_oe;
    logic        exp_ctrl_oe;
    logic        exp_par;
    logic        exp_par_oe;
  } pin_state_t;

  localparam pin_state_t PINS_IN_RESET = '{
    host_addr: '0, host_addr_oe: 1'b1, tag_data: '0, tag_data_oe: 1'b1,
    exp_ad: '0, exp_ad_oe: 1'b1, exp_cbe: '0, exp_cbe_oe: 1'b1,
    host_addr_hold: 1'b1, host_burst_ready_n: 1'b1, host_next_addr_n: 1'b1,
    host_snoop_strobe_n: 1'b1, host_backoff_n: 1'b1, tag_write_enable_n: 1'b0,
    dram_row_strobe_n: '0, dram_clk_en: '0, exp_grant_n: '1, exp_grant_oe: 1'b0,
    exp_ctrl_oe: 1'b0, exp_par: 1'b0, exp_par_oe: 1'b1};

  localparam pin_state_t PINS_AFTER_RESET = '{
    host_addr: '0, host_addr_oe: 1'b0, tag_data: '0, tag_data_oe: 1'b0,
    exp_ad: '0, exp_ad_oe: 1'b0, exp_cbe: '0, exp_cbe_oe: 1'b0,
    host_addr_hold: 1'b0, host_burst_ready_n: 1'b1, host_next_addr_n: 1'b1,
    host_snoop_strobe_n: 1'b1, host_backoff_n: 1'b1, tag_write_enable_n: 1'b1,
    dram_row_strobe_n: '1, dram_clk_en: '1, exp_grant_n: '1, exp_grant_oe: 1'b1,
    exp_ctrl_oe: 1'b0, exp_par: 1'b0, exp_par_oe: 1'b1};

endpackage

/* File: hw/byte_lane_reg.sv */
`timescale 1ns/1ns
module byte_lane_reg #(
  parameter logic [31:0] RST_VAL  = 32'h0000_0000,
  parameter logic [31:0] RW_MASK  = 32'h0000_0000,
  parameter logic [31:0] W1C_MASK = 32'h0000_0000
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_wdata,
  input  wire logic [31:0] i_set,
  output logic      [31:0] o_q
);
  logic [31:0] q_ff;
  assign o_q = q_ff;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] nxt_byte;
    logic [7:0] rw_m;
    logic [7:0] c_m;
    logic [7:0] wd;
    assign rw_m = RW_MASK[8*b +: 8];
    assign c_m  = W1C_MASK[8*b +: 8];
    assign wd   = i_wdata[8*b +: 8];
    always_comb begin
      nxt_byte = q_ff[8*b +: 8];
      if (i_wr && i_be[b]) begin // RL18
        nxt_byte = (nxt_byte & ~rw_m) | (wd & rw_m); // RL4
        nxt_byte = nxt_byte & ~(wd & c_m); // RL5
      end
      // hardware set wins over a same-cycle clear
      nxt_byte = nxt_byte | (i_set[8*b +: 8] & c_m);
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        q_ff[8*b +: 8] <= RST_VAL[8*b +: 8]; // RL10
      end else begin
        q_ff[8*b +: 8] <= nxt_byte;
      end
    end
  end
endmodule // byte_lane_reg

/* File: hw/host_config_regs.sv */
// Behaviour
// (RL1) only host accesses reach the registers
// (RL2) byte, word, dword; address register dword only
// (RL3) multi-byte fields little-endian by lane
// (RL4) writes to read-only registers are ignored
// (RL5) write one clears, zero keeps
// (RL6) software read-merge-writes reserved bits
// (RL7) reserved config locations complete, read zero
// (RL8) undefined locations read-only, read non-zero
// (RL9) software avoids writing reserved device region
// (RL10) hard reset loads fixed defaults
// (RL11) address, data window, power block in i/o
// (RL12) address, tag, ad, cbe low then released
// (RL13) undefined-state outputs are still driven
// (RL14) hold high then low; strobes stay high
// (RL15) tag we low then high; dram high (dram row strobes and clock enables are driven low in reset, high after)
// (RL16) grants released then high; ctrl released
// (RL17) all logic on the host clock
// (RL18) narrow writes touch only addressed lanes
`timescale 1ns/1ns
module host_config_regs #(
  parameter logic [31:0] DEVICE_ID_WORD = 32'h1234_5678, // arbitrary identity value
  parameter logic [31:0] UNDEF_WORD     = 32'h0000_00a5  // arbitrary non-zero value
) (
  input  wire logic                     i_sys_clk, // RL17
  input  wire logic                     i_rst_n,
  input  wire host_cfg_pkg::host_req_t  i_req,
  input  wire logic [1:0]               i_status_evt,
  output host_cfg_pkg::host_rsp_t       o_rsp,
  output host_cfg_pkg::pin_state_t      o_pins,
  output logic                          o_arb_disable,
  output logic                          o_mem_enable
);
  import host_cfg_pkg::*;

  logic        host_ok;
  logic        hit_pm2;
  logic        hit_addr;
  logic        hit_data;
  logic        cfg_sel;
  logic [7:0]  cfg_ofs;
  logic        wr_req;
  logic        rd_req;
  logic        wr_pm2;
  logic        wr_addr;
  logic        wr_cmd;
  logic        wr_scratch;
  logic [3:0]  pm2_be;
  logic [31:0] pm2_wdata;
  logic [31:0] pm2_q;
  logic [31:0] addr_q;
  logic [31:0] cmd_q;
  logic [31:0] scratch_q;
  logic [31:0] evt_set;
  logic [31:0] cfg_word;
  logic [31:0] nxt_rdata;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  pin_state_t  pins_ff;
  logic        arb_dis_ff;
  logic        mem_en_ff;

  // expansion-side masters get a completed but inert cycle
  assign host_ok  = i_req.valid && !i_req.from_expansion; // RL1
  // x86-style dword address with lane enables carries the byte position
  assign hit_pm2  = i_req.addr[15:2] == IO_PM2_ADDR[15:2]; // RL11
  // narrow access to the address register is acked and dropped, no pass-through
  assign hit_addr = i_req.addr[15:2] == IO_CFG_ADDR_ADDR[15:2]
                    && i_req.be == BE_DWORD; // RL2
  assign hit_data = i_req.addr[15:2] == IO_CFG_DATA_ADDR[15:2];
  // window opens only for our own bus, device and function zero
  assign cfg_sel  = addr_q[CFG_EN_BIT] && addr_q[CFG_BUS_LSB +: 8] == 8'h00
                    && addr_q[CFG_DEV_LSB +: 5] == 5'h00
                    && addr_q[CFG_FN_LSB +: 3] == 3'h0; // RL11
  assign cfg_ofs  = {addr_q[CFG_REG_LSB +: 6], 2'b00};

  assign wr_req     = host_ok && i_req.write;
  assign rd_req     = host_ok && !i_req.write;
  assign wr_pm2     = wr_req && hit_pm2;
  assign wr_addr    = wr_req && hit_addr; // RL2
  assign wr_cmd     = wr_req && hit_data && cfg_sel
                      && cfg_ofs == CFG_CMD_STS_OFS;
  assign wr_scratch = wr_req && hit_data && cfg_sel
                      && cfg_ofs == CFG_SCRATCH_OFS;
  assign evt_set    = {2'b00, i_status_evt, 28'h000_0000};
  // pm2 is one byte in its own lane of the dword; kept at bits 7:0 inside
  assign pm2_be     = {3'b000, i_req.be[IO_PM2_ADDR[1:0]]}; // RL3
  assign pm2_wdata  = {24'h00_0000, i_req.wdata[8*IO_PM2_ADDR[1:0] +: 8]}; // RL3

  byte_lane_reg #(
    .RST_VAL (PM2_RST),
    .RW_MASK (PM2_RW_MASK),
    .W1C_MASK(ZERO_WORD)
  ) u_pm2 (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_wr     (wr_pm2),
    .i_be     (pm2_be),
    .i_wdata  (pm2_wdata),
    .i_set    (ZERO_WORD),
    .o_q      (pm2_q)
  );

  byte_lane_reg #(
    .RST_VAL (CFG_ADDR_RST),
    .RW_MASK (CFG_ADDR_RW_MASK),
    .W1C_MASK(ZERO_WORD)
  ) u_cfg_address_reg (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_wr     (wr_addr),
    .i_be     (i_req.be),
    .i_wdata  (i_req.wdata),
    .i_set    (ZERO_WORD),
    .o_q      (addr_q)
  );

  byte_lane_reg #(
    .RST_VAL (CMD_STS_RST),
    .RW_MASK (CMD_STS_RW_MASK),
    .W1C_MASK(CMD_STS_W1C_MASK)
  ) u_cmd_sts (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_wr     (wr_cmd),
    .i_be     (i_req.be),
    .i_wdata  (i_req.wdata),
    .i_set    (evt_set),
    .o_q      (cmd_q)
  );

  byte_lane_reg #(
    .RST_VAL (SCRATCH_RST),
    .RW_MASK (SCRATCH_RW_MASK),
    .W1C_MASK(ZERO_WORD)
  ) u_scratch (
    .i_sys_clk(i_sys_clk),
    .i_rst_n  (i_rst_n),
    .i_wr     (wr_scratch),
    .i_be     (i_req.be),
    .i_wdata  (i_req.wdata),
    .i_set    (ZERO_WORD),
    .o_q      (scratch_q)
  );

  always_comb begin
    case (cfg_ofs)
      CFG_ID_OFS:      cfg_word = DEVICE_ID_WORD; // RL4
      CFG_CMD_STS_OFS: cfg_word = cmd_q;
      CFG_SCRATCH_OFS: cfg_word = scratch_q;
      CFG_UNDEF_OFS:   cfg_word = UNDEF_WORD; // RL8
      default:         cfg_word = ZERO_WORD; // RL7
    endcase
  end

  // lanes not enabled read zero so byte n always sits at bits 8n+7:8n
  always_comb begin
    nxt_rdata = ZERO_WORD;
    if (rd_req) begin
      if (hit_pm2) begin
        nxt_rdata[8*IO_PM2_ADDR[1:0] +: 8] = pm2_q[7:0]; // RL3
      end else if (hit_addr) begin
        nxt_rdata = addr_q;
      end else if (hit_data) begin
        nxt_rdata = cfg_sel ? cfg_word : UNMAPPED_CFG_READ;
      end
      for (int b = 0; b < 4; b++) begin
        if (!i_req.be[b]) begin
          nxt_rdata[8*b +: 8] = 8'h00; // RL3
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= i_req.valid; // RL7
    end
  end

  // zero when idle, so a late sampler never picks up stale data
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= ZERO_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arb_dis_ff <= 1'b0;
    end else begin
      arb_dis_ff <= pm2_q[PM2_ARB_DIS_BIT];
    end
  end

  // one edge behind the register, so users see it a cycle after the ack
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_en_ff <= 1'b0;
    end else begin
      mem_en_ff <= cmd_q[CMD_MEM_EN_BIT];
    end
  end

  // every pin flop is a constant under reset; only the grant and ctrl outputs float
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_ff <= PINS_IN_RESET; // RL12 RL13 RL14 RL15 RL16
    end else begin
      pins_ff <= PINS_AFTER_RESET; // RL12 RL14 RL15 RL16
    end
  end

  assign o_rsp         = '{ack: ack_ff, rdata: rdata_ff};
  assign o_pins        = pins_ff;
  assign o_arb_disable = arb_dis_ff;
  assign o_mem_enable  = mem_en_ff;
endmodule // host_config_regs

/* File: testbench/host_config_regs_props.sv */
`timescale 1ns/1ns
module host_config_regs_props (
  input wire logic                     i_sys_clk,
  input wire logic                     i_rst_n,
  input wire host_cfg_pkg::host_req_t  i_req,
  input wire logic [1:0]               i_status_evt,
  input wire host_cfg_pkg::host_rsp_t  o_rsp,
  input wire host_cfg_pkg::pin_state_t o_pins,
  input wire logic                     o_arb_disable,
  input wire logic                     o_mem_enable
);
  import host_cfg_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_req.valid;
  endsequence
  sequence s_read;
    s_take ##0 !i_req.write;
  endsequence
  a_ack_pulse: assert property (s_take |=> o_rsp.ack) else $error("ack missing");
  a_no_stray: assert property (!i_req.valid |=> !o_rsp.ack && o_rsp.rdata == ZERO_WORD)
    else $error("response without request");
  a_exp_blocked: assert property (s_take ##0 i_req.from_expansion
    |=> o_rsp.rdata == ZERO_WORD) else $error("expansion access saw data");
  a_cfg_dword: assert property (s_read ##0 (i_req.addr == IO_CFG_ADDR_ADDR)
    ##0 (i_req.be != BE_DWORD) |=> o_rsp.rdata == ZERO_WORD) else $error("narrow address read");
  a_lane_zero: assert property (s_read ##0 !i_req.be[0] |=> o_rsp.rdata[7:0] == 8'h00)
    else $error("disabled lane carried data");
  a_reset_pins: assert property (disable iff (1'b0) !i_rst_n
    |-> o_pins == PINS_IN_RESET) else $error("pins wrong in reset");
  a_bus_released: assert property ($past(i_rst_n) |-> !o_pins.host_addr_oe
    && !o_pins.tag_data_oe && !o_pins.exp_ad_oe && !o_pins.exp_cbe_oe)
    else $error("bus still driven");
  a_hold_strobes: assert property ($past(i_rst_n) |-> !o_pins.host_addr_hold &&
    {o_pins.host_burst_ready_n, o_pins.host_next_addr_n, o_pins.host_snoop_strobe_n,
     o_pins.host_backoff_n} == 4'hf) else $error("host strobes wrong");
  a_tag_dram: assert property ($past(i_rst_n) |-> o_pins.tag_write_enable_n &&
    &o_pins.dram_row_strobe_n && &o_pins.dram_clk_en) else $error("tag or dram wrong");
  a_grant_ctrl: assert property ($past(i_rst_n) |-> o_pins.exp_grant_oe &&
    &o_pins.exp_grant_n && !o_pins.exp_ctrl_oe) else $error("grant or ctrl wrong");
endmodule // host_config_regs_props

/* File: testbench/host_cpu_model.sv */
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic                    i_sys_clk,
  input  wire host_cfg_pkg::host_rsp_t i_rsp,
  output host_cfg_pkg::host_req_t      o_req
);
  import host_cfg_pkg::*;
  initial o_req = '0;
  // pulse of one cycle; write data scrambled once taken so stale lanes never match
  task automatic io(input bit w, input bit x, input logic [15:0] a, input logic [3:0] b,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge i_sys_clk);
    o_req <= '{valid: 1'b1, write: w, from_expansion: x, addr: a, be: b, wdata: d};
    @(posedge i_sys_clk);
    o_req.valid <= 1'b0;
    o_req.wdata <= ~d;
    @(posedge i_sys_clk);
    q = i_rsp.rdata;
  endtask
  task automatic rmw(input logic [15:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    io(1'b0, 1'b0, a, BE_DWORD, 32'h0, q);
    io(1'b1, 1'b0, a, BE_DWORD, (q & ~m) | (v & m), q);
  endtask
endmodule // host_cpu_model

/* File: testbench/host_config_regs_bench.sv */
`timescale 1ns/1ns
module host_config_regs_bench;
  import host_cfg_pkg::*;
  typedef struct packed {
    logic        w;
    logic        x;
    logic [15:0] a;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  localparam logic [31:0] ID_W  = 32'h0bad_cafe; // arbitrary identity value
  localparam logic [31:0] UND_W = 32'h0000_005a; // arbitrary non-zero value
  localparam logic [15:0] CA    = IO_CFG_ADDR_ADDR;
  localparam logic [15:0] CD    = IO_CFG_DATA_ADDR;
  logic        i_sys_clk;
  logic        i_rst_n = 1'b1;
  logic [1:0]  i_status_evt;
  host_req_t   req;
  host_rsp_t   rsp;
  pin_state_t  pins;
  logic        arb_dis;
  logic        mem_en;
  int          fails;
  int          num_checks;
  int          cycles;
  logic [31:0] q;
  row_t        rows[$];
  host_cpu_model cpu_u (.i_sys_clk(i_sys_clk), .i_rsp(rsp), .o_req(req));
  host_config_regs #(.DEVICE_ID_WORD(ID_W), .UNDEF_WORD(UND_W)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(req), .i_status_evt(i_status_evt),
    .o_rsp(rsp), .o_pins(pins), .o_arb_disable(arb_dis), .o_mem_enable(mem_en));
  function automatic row_t r(bit w, bit x, logic [15:0] a, logic [3:0] b, logic [31:0] d,
                             logic [31:0] e);
    return {w, x, a, b, d, e};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input pin_state_t got, input pin_state_t exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    // nba at time zero so the async reset edge is never missed
    i_rst_n <= 1'b0;
    i_status_evt = 2'h0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    rows = '{r(1, 0, CA, 4'hf, 32'h8000_0000, 32'h0),
             r(0, 0, CA, 4'hf, 32'h0, 32'h8000_0000),
             r(0, 0, CA, 4'h3, 32'h0, 32'h0),
             r(1, 0, CA, 4'h3, 32'h0000_1234, 32'h0),
             r(0, 0, CA, 4'hf, 32'h0, 32'h8000_0000),
             r(1, 0, CD, 4'hf, 32'hffff_ffff, 32'h0),
             r(0, 0, CD, 4'hf, 32'h0, ID_W),
             r(1, 0, CA, 4'hf, 32'h8000_0050, 32'h0),
             r(1, 0, CD, 4'hf, 32'h1122_3344, 32'h0),
             r(1, 0, CD, 4'h2, 32'h0000_aa00, 32'h0),
             r(0, 0, CD, 4'hf, 32'h0, 32'h1122_aa44),
             r(0, 0, CD, 4'h4, 32'h0, 32'h0022_0000),
             r(1, 0, CA, 4'hf, 32'h8000_0054, 32'h0),
             r(0, 0, CD, 4'h3, 32'h0, {16'h0000, UND_W[15:0]}),
             r(0, 0, CD, 4'hf, 32'h0, UND_W),
             r(1, 0, CA, 4'hf, 32'h8000_0058, 32'h0),
             r(0, 0, CD, 4'hf, 32'h0, 32'h0),
             r(1, 1, CA, 4'hf, 32'h0, 32'h0),
             r(0, 1, CA, 4'hf, 32'h0, 32'h0),
             r(0, 0, CA, 4'hf, 32'h0, 32'h8000_0058),
             r(1, 0, CA, 4'hf, 32'h0000_0050, 32'h0),
             r(0, 0, CD, 4'hf, 32'h0, 32'hffff_ffff),
             r(0, 0, 16'h0100, 4'hf, 32'h0, 32'h0)};
    repeat (6) @(posedge i_sys_clk);
    chkp(pins, PINS_IN_RESET);
    i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      cpu_u.io(rows[i].w, rows[i].x, rows[i].a, rows[i].be, rows[i].d, q);
      if (!rows[i].w) chk(q, rows[i].e);
    end
    $display("test table done");
    cpu_u.io(1'b1, 1'b0, CA, 4'hf, 32'h8000_0004, q);
    chk({31'h0, mem_en}, 32'h1);
    @(posedge i_sys_clk);
    i_status_evt <= 2'h3;
    @(posedge i_sys_clk);
    i_status_evt <= 2'h0;
    cpu_u.io(1'b0, 1'b0, CD, 4'hf, 32'h0, q);
    chk(q, 32'h3000_0006);
    cpu_u.io(1'b1, 1'b0, CD, 4'hf, 32'h1000_0006, q);
    cpu_u.io(1'b0, 1'b0, CD, 4'hf, 32'h0, q);
    chk(q, 32'h2000_0006);
    cpu_u.io(1'b1, 1'b0, CD, 4'hf, 32'h0000_0000, q);
    cpu_u.io(1'b0, 1'b0, CD, 4'hf, 32'h0, q);
    chk(q, 32'h2000_0000);
    chk({31'h0, mem_en}, 32'h0);
    $display("test clear bits done");
    cpu_u.io(1'b0, 1'b0, IO_PM2_ADDR, 4'hf, 32'h0, q);
    chk(q, {8'h00, PM2_RST[7:0], 16'h0000});
    cpu_u.rmw(IO_PM2_ADDR, 32'h0001_0000, 32'h0001_0000);
    cpu_u.io(1'b0, 1'b0, IO_PM2_ADDR, 4'h4, 32'h0, q);
    chk(q, 32'h0001_0000);
    chk({31'h0, arb_dis}, 32'h1);
    $display("test pm2 done");
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    @(posedge i_sys_clk);
    chkp(pins, PINS_IN_RESET);
    chk({31'h0, arb_dis}, 32'h0);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    chkp(pins, PINS_AFTER_RESET);
    cpu_u.io(1'b0, 1'b0, CA, 4'hf, 32'h0, q);
    chk(q, CFG_ADDR_RST);
    $display("test reset done");
    final_report;
  end
endmodule // host_config_regs_bench
bind host_config_regs host_config_regs_props props_u (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_status_evt(i_status_evt),
  .o_rsp(o_rsp), .o_pins(o_pins), .o_arb_disable(o_arb_disable), .o_mem_enable(o_mem_enable));
